// [design/scbr_pkg.sv]
/*
  Shared constants and carrier types for the movement-sensor register bank:
  register offsets, field positions, reset values, timing counts, the access
  request struct.
  Assumes a single 50 MHz clock domain.
*/
package scbr_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] SCBR_ILLUM_ADDR = 8'h40;
  localparam logic [7:0] SCBR_IRQCFG_ADDR = 8'h41;
  localparam logic [7:0] SCBR_BSTART_ADDR = 8'h42;
  localparam logic [7:0] SCBR_BEND_ADDR = 8'h44;
  localparam logic [7:0] SCBR_REST_ADDR = 8'h45;
  localparam logic [7:0] SCBR_BPORT_ADDR = 8'h63;

  // Reset values
  localparam logic [7:0] SCBR_ILLUM_RST = 8'h00;
  localparam logic [7:0] SCBR_IRQCFG_RST = 8'h40;
  localparam logic [7:0] SCBR_BSTART_RST = 8'h03;
  localparam logic [7:0] SCBR_BEND_RST = 8'h09;
  localparam logic [1:0] SCBR_REST_RST = 2'h0;
  localparam logic [7:0] SCBR_BPORT_RST = 8'h00;

  // Field positions
  localparam int SCBR_ILLUM_OFF_BIT = 3;
  localparam int SCBR_IRQ_POL_BIT = 7;
  localparam int SCBR_IRQ_EDGE_BIT = 6;
  localparam int SCBR_REST_HI = 7;
  localparam int SCBR_REST_LO = 6;

  // Edge-mode pulse: about 380 ns, rounded down to whole 20 ns cycles
  localparam int SCBR_CLK_PERIOD_NS = 20;
  localparam int SCBR_PULSE_NS = 380;
  localparam int SCBR_PULSE_CYC = SCBR_PULSE_NS / SCBR_CLK_PERIOD_NS;

  // Rest levels
  typedef enum logic [1:0] {
    SCBR_MODE_NORMAL,
    SCBR_MODE_REST1,
    SCBR_MODE_REST2,
    SCBR_MODE_REST3
  } scbr_mode_e;

  // One register access from the serial port engine
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } scbr_req_s;

endpackage

// [design/scbr_pulse.sv]
/*
  Fixed-length pulse stretcher for the edge-sensitive movement output.
  Assumes the trigger is a synchronous one-cycle strobe on clk_in.
*/
`timescale 1ns/1ps
module scbr_pulse
  import scbr_pkg::*;
#(
  parameter int LEN = SCBR_PULSE_CYC
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Trigger and stretched output
  input wire logic trig_in,
  output logic busy_out
);

  logic [7:0] cnt_reg; // Cycles left in the current pulse
  logic [7:0] cnt_next;

  // A trigger during a running pulse is dropped, so one pulse per event burst
  assign cnt_next = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 :
                    trig_in ? 8'(LEN) : 8'h00;
  assign busy_out = (cnt_reg != 8'h00);

  // Counter
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      cnt_reg <= 8'h00;
    else
      cnt_reg <= cnt_next;
  end

endmodule // scbr_pulse

// [design/scbr_regs.sv]
/*
  Register bank of the movement sensor: illumination control, movement
  output configuration and drive, burst read sequencing, rest mode force.
  Assumes a serial port engine that turns each serial transfer into one
  request cycle, and a datapath that answers other addresses combinationally.
*/
`timescale 1ns/1ps
module scbr_regs
  import scbr_pkg::*;
#(
  parameter logic [7:0] DY_ADDR = 8'h04, // Y displacement register offset
  parameter int PULSE_LEN = SCBR_PULSE_CYC
)
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Register access from the serial port engine
  input wire scbr_req_s req_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  // Datapath register space
  output logic [7:0] ext_addr_out,
  input wire logic [7:0] ext_rdata_in,
  // Movement datapath
  input wire logic motion_detect_in,
  input wire logic delta_nonzero_in,
  output logic delta_clear_out,
  // Power manager
  input wire logic [1:0] cur_mode_in,
  output logic [1:0] force_mode_out,
  // Pins
  output logic illum_off_out,
  output logic motion_out
);

  // Software registers
  logic illum_force_off; // Light source forced off
  logic irq_polarity; // 1: active high
  logic irq_edge_select; // 1: edge pulse, 0: level
  logic [7:0] burst_start_reg;
  logic [7:0] burst_end_reg;
  scbr_mode_e rest_level_field; // Forced rest level, normal = no force

  // Burst and movement state
  logic burst_active_reg; // Burst in progress
  logic [7:0] burst_ptr_reg; // Next address to return
  logic pending_reg; // Level mode: unread displacement held
  logic pulse_busy; // Edge mode pulse running
  logic [7:0] rdata_next;
  logic motion_next;

  // Decoded strobes
  wire wr_illum = req_in.wr && req_in.addr == SCBR_ILLUM_ADDR;
  wire wr_irqcfg = req_in.wr && req_in.addr == SCBR_IRQCFG_ADDR;
  wire wr_bstart = req_in.wr && req_in.addr == SCBR_BSTART_ADDR;
  wire wr_bend = req_in.wr && req_in.addr == SCBR_BEND_ADDR;
  wire wr_rest = req_in.wr && req_in.addr == SCBR_REST_ADDR;
  wire rd_bport = req_in.rd && !burst_active_reg && req_in.addr == SCBR_BPORT_ADDR;

  // Address actually read: burst pointer, burst start, or the request itself
  wire [7:0] eff_addr = burst_active_reg ? burst_ptr_reg :
                        (req_in.addr == SCBR_BPORT_ADDR) ? burst_start_reg :
                        req_in.addr;
  wire burst_last = (eff_addr == burst_end_reg);
  // A burst ends on the byte from the end address
  wire burst_go = req_in.rd && (rd_bport || burst_active_reg) && !burst_last;
  // Y read marks all pending displacement consumed
  wire rd_dy = req_in.rd && eff_addr == DY_ADDR;

  assign ext_addr_out = eff_addr;
  assign illum_off_out = illum_force_off;
  assign force_mode_out = rest_level_field;

  // Read mux: own registers first, everything else from the datapath
  always_comb
  begin
    case (eff_addr)
      SCBR_ILLUM_ADDR: rdata_next = {4'h0, illum_force_off, 3'h0};
      SCBR_IRQCFG_ADDR: rdata_next = {irq_polarity, irq_edge_select, 6'h00};
      SCBR_BSTART_ADDR: rdata_next = burst_start_reg;
      SCBR_BEND_ADDR: rdata_next = burst_end_reg;
      // Live mode, not the forced value
      SCBR_REST_ADDR: rdata_next = {cur_mode_in, 6'h00};
      SCBR_BPORT_ADDR: rdata_next = SCBR_BPORT_RST;
      default: rdata_next = ext_rdata_in;
    endcase
  end

  // Configuration registers
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      illum_force_off <= SCBR_ILLUM_RST[SCBR_ILLUM_OFF_BIT];
      irq_polarity <= SCBR_IRQCFG_RST[SCBR_IRQ_POL_BIT];
      irq_edge_select <= SCBR_IRQCFG_RST[SCBR_IRQ_EDGE_BIT];
      burst_start_reg <= SCBR_BSTART_RST;
      burst_end_reg <= SCBR_BEND_RST;
      rest_level_field <= scbr_mode_e'(SCBR_REST_RST);
    end
    else
    begin
      if (wr_illum)
        illum_force_off <= req_in.wdata[SCBR_ILLUM_OFF_BIT];
      if (wr_irqcfg)
      begin
        irq_polarity <= req_in.wdata[SCBR_IRQ_POL_BIT];
        irq_edge_select <= req_in.wdata[SCBR_IRQ_EDGE_BIT];
      end
      if (wr_bstart)
        burst_start_reg <= req_in.wdata;
      if (wr_bend)
        burst_end_reg <= req_in.wdata;
      // Reserved bits ignored; bits 7:6 at 0 release, other values there force a level
      if (wr_rest)
        rest_level_field <= scbr_mode_e'(req_in.wdata[SCBR_REST_HI:SCBR_REST_LO]);
    end
  end

  // Burst sequencer; a write abandons an unfinished burst
  always_ff @(posedge clk_in)
  begin
    if (srst_in || req_in.wr)
    begin
      burst_active_reg <= 1'b0;
      burst_ptr_reg <= 8'h00;
    end
    else if (req_in.rd)
    begin
      burst_active_reg <= burst_go;
      burst_ptr_reg <= eff_addr + 8'h01;
    end
  end

  // Read data, one cycle after the request
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      rdata_out <= 8'h00;
      rvalid_out <= 1'b0;
    end
    else
    begin
      rvalid_out <= req_in.rd;
      if (req_in.rd)
        rdata_out <= rdata_next;
    end
  end

  // Pending displacement; a new movement in the clearing cycle wins
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      pending_reg <= 1'b0;
    else if (motion_detect_in && delta_nonzero_in)
      pending_reg <= 1'b1;
    else if (rd_dy)
      pending_reg <= 1'b0;
  end

  // Clear strobe to the datapath after the Y byte has been taken in level mode
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      delta_clear_out <= 1'b0;
    else
      delta_clear_out <= rd_dy && !irq_edge_select;
  end

  // Edge mode pulse timer
  scbr_pulse #(
    .LEN(PULSE_LEN)
  ) u_pulse (
    .clk_in(clk_in),
    .srst_in(srst_in),
    .trig_in(motion_detect_in && irq_edge_select),
    .busy_out(pulse_busy)
  );

  // Active level follows polarity; idle level is its inverse
  assign motion_next = irq_edge_select ? (pulse_busy ~^ irq_polarity)
                                       : (pending_reg ~^ irq_polarity);

  // Registered pin; idles high, matching the default active-low setting
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      motion_out <= 1'b1;
    else
      motion_out <= motion_next;
  end

  // Checks

  // Check helpers: a configuration write leaves the pin one cycle stale
  logic cfg_chg_reg; // Movement output configuration written last cycle
  logic [7:0] act_run_reg; // Consecutive active cycles of the pin, edge mode

  // Remember a configuration write for one cycle
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      cfg_chg_reg <= 1'b0;
    else
      cfg_chg_reg <= wr_irqcfg;
  end

  // Run length of the active level; 0xFF marks a run disturbed by software,
  // so a pulse cut short by a configuration write is never judged
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
      act_run_reg <= 8'h00;
    else if (wr_irqcfg || cfg_chg_reg || !irq_edge_select)
      act_run_reg <= 8'hFF; // History unknown
    else if (motion_out != irq_polarity)
      act_run_reg <= 8'h00; // Pin idle
    else if (act_run_reg != 8'hFF)
      act_run_reg <= act_run_reg + 8'h01;
  end

  // Level mode movement with displacement pending, configuration untouched
  sequence s_level_hit;
    !irq_edge_select && motion_detect_in && delta_nonzero_in && !wr_irqcfg;
  endsequence

  // First idle cycle after an undisturbed edge mode pulse
  sequence s_pulse_end;
    irq_edge_select && !cfg_chg_reg && motion_out != irq_polarity
      && act_run_reg != 8'h00 && act_run_reg != 8'hFF;
  endsequence

  property p_illum_write;
    @(posedge clk_in) disable iff (srst_in)
      wr_illum |=> illum_off_out == $past(req_in.wdata[SCBR_ILLUM_OFF_BIT]);
  endproperty
  a_illum_write: assert property (p_illum_write) else $error("illum off wrong");

  property p_cfg_reset;
    @(posedge clk_in) disable iff (srst_in)
      $fell(srst_in) |-> irq_edge_select && !irq_polarity;
  endproperty
  a_cfg_reset: assert property (p_cfg_reset) else $error("irq config reset");

  property p_level_idle;
    @(posedge clk_in) disable iff (srst_in)
      !irq_edge_select && !pending_reg && $stable(irq_polarity) && !wr_irqcfg
      |=> motion_out == !irq_polarity;
  endproperty
  a_level_idle: assert property (p_level_idle) else $error("level idle");

  // Pin goes active two cycles after the detect unless software rewrites
  property p_level_active;
    @(posedge clk_in) disable iff (srst_in)
      s_level_hit ##1 !wr_irqcfg |=> motion_out == irq_polarity;
  endproperty
  a_level_active: assert property (p_level_active) else $error("level active");

  property p_level_clear;
    @(posedge clk_in) disable iff (srst_in)
      !irq_edge_select && rd_dy && !motion_detect_in && !wr_irqcfg
      |=> delta_clear_out && !pending_reg;
  endproperty
  a_level_clear: assert property (p_level_clear) else $error("clear missed");

  // Every undisturbed pulse lasts exactly the configured number of cycles
  property p_edge_pulse;
    @(posedge clk_in) disable iff (srst_in)
      s_pulse_end |-> act_run_reg == 8'(PULSE_LEN);
  endproperty
  a_edge_pulse: assert property (p_edge_pulse) else $error("pulse length");

  property p_burst_reset;
    @(posedge clk_in) disable iff (srst_in)
      $fell(srst_in) |-> burst_start_reg == SCBR_BSTART_RST && burst_end_reg == SCBR_BEND_RST;
  endproperty
  a_burst_reset: assert property (p_burst_reset) else $error("burst reset");

  property p_rest_read;
    @(posedge clk_in) disable iff (srst_in)
      req_in.rd && eff_addr == SCBR_REST_ADDR
      |=> rvalid_out && rdata_out == {$past(cur_mode_in), 6'h00};
  endproperty
  a_rest_read: assert property (p_rest_read) else $error("rest read");

  property p_rest_force;
    @(posedge clk_in) disable iff (srst_in)
      wr_rest |=> force_mode_out == $past(req_in.wdata[SCBR_REST_HI:SCBR_REST_LO]);
  endproperty
  a_rest_force: assert property (p_rest_force) else $error("rest force");

  property p_burst_start;
    @(posedge clk_in) disable iff (srst_in)
      rd_bport |-> ext_addr_out == burst_start_reg;
  endproperty
  a_burst_start: assert property (p_burst_start) else $error("burst start");

  property p_burst_step;
    @(posedge clk_in) disable iff (srst_in)
      burst_active_reg && req_in.rd
      |=> (burst_active_reg && burst_ptr_reg == $past(burst_ptr_reg) + 8'h01)
          || (!burst_active_reg && $past(burst_last));
  endproperty
  a_burst_step: assert property (p_burst_step) else $error("burst step");

endmodule // scbr_regs

// [tb/scbr_dp_model.sv]
/*
  Stand-in for the sensor datapath register space behind the bank.
  Assumes it is read combinationally by address in the same cycle.
*/
`timescale 1ns/1ps
module scbr_dp_model
(
  // Address from the bank
  input wire logic [7:0] addr_in,
  // Byte for that address
  output logic [7:0] data_out
);
  // Scrambled so every address gives a distinct byte, never the address itself
  assign data_out = addr_in ^ 8'h5A;
endmodule // scbr_dp_model

// [tb/testbench.sv]
/*
  Self-checking bench for the movement-sensor register bank.
  Assumes a 50 MHz clock and the datapath model answering other addresses.
*/
`timescale 1ns/1ps
module testbench
  import scbr_pkg::*;
;
  localparam int PLEN = 3; // Short pulse keeps the run brief
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] val;
  } scbr_row_s;
  logic clk_in, srst_in, rvalid, detect, dnz, dclr, illum_off, motion;
  logic [7:0] rdata, ext_addr, ext_rdata, cfg;
  logic [1:0] cur_mode, force_mode;
  scbr_req_s req;
  int err_count, checks_done, n;
  int nclr = 0; // Clear strobes seen; written only by its counter process
  // Register traffic table: write val, or read and expect val
  scbr_row_s rows [12] = '{
    '{1'h0, 8'h40, 8'h00}, '{1'h0, 8'h41, 8'h40}, '{1'h0, 8'h42, 8'h03},
    '{1'h0, 8'h44, 8'h09}, '{1'h1, 8'h40, 8'hFF}, '{1'h0, 8'h40, 8'h08},
    '{1'h1, 8'h41, 8'hFF}, '{1'h0, 8'h41, 8'hC0}, '{1'h1, 8'h42, 8'h05},
    '{1'h0, 8'h42, 8'h05}, '{1'h1, 8'h44, 8'h07}, '{1'h0, 8'h44, 8'h07}};
  logic [7:0] rest_v [4] = '{8'h40, 8'h80, 8'hC0, 8'h00};

  scbr_regs #(.PULSE_LEN(PLEN)) u_scbr_regs (
    .clk_in(clk_in), .srst_in(srst_in), .req_in(req), .rdata_out(rdata),
    .rvalid_out(rvalid), .ext_addr_out(ext_addr), .ext_rdata_in(ext_rdata),
    .motion_detect_in(detect), .delta_nonzero_in(dnz), .delta_clear_out(dclr),
    .cur_mode_in(cur_mode), .force_mode_out(force_mode),
    .illum_off_out(illum_off), .motion_out(motion));
  scbr_dp_model u_scbr_dp_model (.addr_in(ext_addr), .data_out(ext_rdata));

  // Clock source
  initial
  begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end

  // Count clear strobes seen
  always @(posedge clk_in)
  begin
    if (dclr === 1'b1) nclr++;
  end

  task end_of_test();
    if (err_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask

  // One request cycle; reads return one edge later with the strobe
  task acc(input int r, input int w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1 req = '{rd: r[0], wr: w[0], addr: a, wdata: d};
    @(posedge clk_in);
    #1 req = '0;
    if (r[0]) chk("rvalid", 8'h01, {7'h0, rvalid});
  endtask

  // One-cycle movement strobe
  task move();
    @(posedge clk_in);
    #1 detect = 1'b1;
    @(posedge clk_in);
    #1 detect = 1'b0;
  endtask

  task do_reset();
    srst_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1 srst_in = 1'b0;
  endtask

  initial
  begin
    srst_in = 1'b1; req = '0; detect = 1'b0; dnz = 1'b0; cur_mode = 2'h2;
    err_count = 0; checks_done = 0;
    do_reset();
    chk("motion idle", 8'h01, {7'h0, motion});
    chk("force reset", 8'h00, {6'h0, force_mode});
    // Reset values, write and read back
    foreach (rows[i])
    begin
      acc(~rows[i].wr, rows[i].wr, rows[i].addr, rows[i].val);
      if (!rows[i].wr) chk("reg", rows[i].val, rdata);
    end
    chk("illum off", 8'h01, {7'h0, illum_off});
    acc(0, 1, 8'h40, 8'hF7);
    chk("illum on", 8'h00, {7'h0, illum_off});
    // Forced rest levels and live mode readback
    foreach (rest_v[i])
    begin
      acc(0, 1, 8'h45, rest_v[i]);
      cur_mode = ~rest_v[i][7:6];
      chk("force", {6'h0, rest_v[i][7:6]}, {6'h0, force_mode});
      acc(1, 0, 8'h45, 8'h00);
      chk("rest rd", {~rest_v[i][7:6], 6'h00}, rdata);
    end
    // Burst 0x05..0x07, start below end; read exactly three bytes
    for (int i = 0; i < 3; i++)
    begin
      acc(1, 0, 8'h63, 8'h00);
      chk("burst", (8'h05 + i[7:0]) ^ 8'h5A, rdata);
    end
    acc(1, 0, 8'h63, 8'h00);
    chk("burst again", 8'h05 ^ 8'h5A, rdata);
    acc(0, 1, 8'h42, 8'h01); // A write also aborts the open burst
    acc(1, 0, 8'h42, 8'h00);
    chk("burst abort", 8'h01, rdata);
    // Edge mode, both polarities
    for (int p = 0; p < 2; p++)
    begin
      cfg = {p[0], 7'h40};
      acc(0, 1, 8'h41, cfg);
      // The registered pin takes the new idle level one edge after the write
      @(posedge clk_in);
      #1 chk("edge idle", {7'h0, ~cfg[7]}, {7'h0, motion});
      move();
      n = 0;
      repeat (30)
      begin
        @(posedge clk_in);
        #1 if (motion === cfg[7]) n++;
      end
      chk("pulse len", PLEN[7:0], n[7:0]);
    end
    // Level mode, both polarities; status, X then Y
    for (int p = 0; p < 2; p++)
    begin
      cfg = {p[0], 7'h00};
      acc(0, 1, 8'h41, cfg);
      dnz = 1'b1;
      move();
      repeat (3) @(posedge clk_in);
      #1 chk("level act", {7'h0, cfg[7]}, {7'h0, motion});
      acc(1, 0, 8'h02, 8'h00);
      acc(1, 0, 8'h03, 8'h00);
      chk("level hold", {7'h0, cfg[7]}, {7'h0, motion});
      n = nclr;
      acc(1, 0, 8'h04, 8'h00);
      repeat (4) @(posedge clk_in);
      #1 dnz = 1'b0;
      chk("clear cnt", 8'h01, 8'(nclr - n));
      chk("level rel", {7'h0, ~cfg[7]}, {7'h0, motion});
    end
    // Mid-run reset restores defaults; light forced off first so it shows
    acc(0, 1, 8'h40, 8'h08);
    do_reset();
    acc(1, 0, 8'h42, 8'h00);
    chk("start rst", 8'h03, rdata);
    chk("illum rst", 8'h00, {7'h0, illum_off});
    end_of_test();
  end

  // Watchdog, far beyond the expected run
  initial
  begin
    #200000;
    err_count++;
    end_of_test();
  end
endmodule // testbench
